// ### ddl_cfg.svh
`ifndef DDL_CFG_SVH
`define DDL_CFG_SVH

// ****************************************************************
// Register map (byte addresses, one 32-bit word each)
// ****************************************************************
`define DDL_OFS_CTRL 8'h00
`define DDL_OFS_STATUS 8'h04
`define DDL_OFS_IN_A 8'h08
`define DDL_OFS_IN_B 8'h0C
`define DDL_OFS_DAC_A 8'h10
`define DDL_OFS_DAC_B 8'h14

// ****************************************************************
// Reset values
// ****************************************************************
`define DDL_CTRL_RST 2'h0
`define DDL_RANGE_RST 1'b0
`define DDL_MODE_RST 2'h0
`define DDL_PIN_RST 5'h1B

// ****************************************************************
// Serial word layout
// ****************************************************************
`define DDL_FRAME_BITS 5'h10
`define DDL_LAST_BIT 5'h0F
`define DDL_BIT_CHAN 15
`define DDL_BIT_RANGE 14
`define DDL_BIT_SEL_HI 13
`define DDL_BIT_SEL_LO 12

// ****************************************************************
// Pin vector positions in the synchroniser
// ****************************************************************
`define DDL_PIN_SYNC 4
`define DDL_PIN_SCLK 3
`define DDL_PIN_DIN 2
`define DDL_PIN_LOAD 1
`define DDL_PIN_SLEEP 0

`endif

// ### ddl_pkg.sv
package ddl_pkg;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_SHIFT = 2'b01,
    FR_DONE = 2'b10
  } ddl_frame_type;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PULL_1K = 2'b01,
    MODE_PULL_100K = 2'b10,
    MODE_HIGH_Z = 2'b11
  } ddl_mode_type;

  typedef enum logic [1:0] {
    RES_12 = 2'b00,
    RES_10 = 2'b01,
    RES_8 = 2'b10
  } ddl_res_type;

endpackage

// ### ddl_top.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "ddl_cfg.svh"
// Contract
// - Word bit 15 picks channel A or B.
// - Bit 14 sets addressed channel output range.
// - Bits 13:12 select the power-down mode.
// - Mode applies only to the addressed channel.
// - Data follows, MSB first, variant masks LSBs.
// - Channel code is plain unsigned binary.
// - Bits accepted only while frame strobe low.
// - Shift one bit per falling serial clock.
// - Edges after the sixteenth are ignored.
// - Full word loads the selected input register.
// - Early strobe rise discards the partial word.
// - Load strobe low makes DAC registers follow.
// - DAC updates only after a new input write.
// - Clear pin zeroes input and DAC registers.
// - Power-on leaves everything zero and normal.
// - Input buffers off after word, on at strobe fall.
// - Power-down leaves register contents unchanged.
// - Sleep pin forces both channels high impedance.
module ddl_top
  import ddl_pkg::*;
#(
  parameter int DW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic load_strobe_n,
  input wire logic zero_all_n,
  input wire logic force_sleep_n,
  output logic [DW-1:0] code_a,
  output logic [DW-1:0] code_b,
  output logic range_a,
  output logic range_b,
  output logic [1:0] mode_a,
  output logic [1:0] mode_b,
  output logic link_awake
);

  // ****************************************************************
  // Pin synchronisers and clear handling
  // ****************************************************************
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [1:0] edge_q;
  logic [1:0] clr_q;
  logic clr_n;
  logic sync_s;
  logic din_s;
  logic load_s;
  logic sleep_s;
  logic sclk_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= `DDL_PIN_RST;
      pin_s2_q <= `DDL_PIN_RST;
      edge_q <= 2'h3;
    end else begin
      pin_s1_q <= {sync_n, sclk, din, load_strobe_n, force_sleep_n};
      pin_s2_q <= pin_s1_q;
      edge_q <= {pin_s2_q[`DDL_PIN_SYNC], pin_s2_q[`DDL_PIN_SCLK]};
    end
  end

  // The clear asserts at once but releases on the clock, so no register
  // leaves reset on a metastable edge.
  always_ff @(posedge pclk or negedge zero_all_n or negedge presetn) begin
    if (!presetn || !zero_all_n) begin
      clr_q <= 2'h0;
    end else begin
      clr_q <= {clr_q[0], 1'b1};
    end
  end

  assign clr_n = clr_q[1];
  assign sync_s = pin_s2_q[`DDL_PIN_SYNC];
  assign din_s = pin_s2_q[`DDL_PIN_DIN];
  assign load_s = pin_s2_q[`DDL_PIN_LOAD];
  assign sleep_s = pin_s2_q[`DDL_PIN_SLEEP];
  assign sclk_fall = edge_q[0] && !pin_s2_q[`DDL_PIN_SCLK];

  // ****************************************************************
  // Frame tracking and shift register
  // ****************************************************************
  ddl_frame_type state_q;
  ddl_frame_type state_d;
  logic [4:0] cnt_q;
  logic [15:0] shift_q;
  logic [15:0] word_d;
  logic commit;
  logic buf_en_q;

  always_comb begin
    state_d = state_q;
    if (sync_s) begin
      state_d = FR_IDLE;
    end else begin
      case (state_q)
        FR_IDLE: state_d = FR_SHIFT;
        FR_SHIFT: begin
          if (sclk_fall && cnt_q == `DDL_LAST_BIT) begin
            state_d = FR_DONE;
          end
        end
        FR_DONE: state_d = FR_DONE;
        default: state_d = FR_IDLE;
      endcase
    end
  end

  // Only the sixteenth edge of a live frame commits; a strobe that rises
  // earlier returns to idle and the partial word is simply dropped.
  assign commit = state_q == FR_SHIFT && !sync_s && sclk_fall
                  && cnt_q == `DDL_LAST_BIT;
  assign word_d = {shift_q[14:0], din_s};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FR_IDLE;
      buf_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      buf_en_q <= state_d == FR_SHIFT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h0;
      shift_q <= 16'h0000;
    end else if (sync_s) begin
      cnt_q <= 5'h0;
    end else if (state_q == FR_SHIFT && sclk_fall) begin
      cnt_q <= cnt_q + 5'h1;
      shift_q <= word_d;
    end
  end

  // ****************************************************************
  // Channel registers
  // ****************************************************************
  logic [1:0] res_q;
  logic [1:0][DW-1:0] in_q;
  logic [1:0][DW-1:0] dac_q;
  logic [1:0] pend_q;
  logic [1:0] range_q;
  logic [1:0][1:0] mode_q;
  logic [1:0][1:0] out_mode_q;

  // Narrower variants keep the word left aligned and zero the dropped LSBs.
  function automatic logic [DW-1:0] mask_code(input logic [15:0] w,
                                              input logic [1:0] res);
    logic [DW-1:0] c;
    c = w[DW-1:0];
    case (res)
      RES_10: c[1:0] = 2'h0;
      RES_8: c[3:0] = 4'h0;
      default: c = w[DW-1:0];
    endcase
    return c;
  endfunction

  always_ff @(posedge pclk or negedge clr_n) begin
    if (!clr_n) begin
      in_q <= '0;
      dac_q <= '0;
      pend_q <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (!load_s && pend_q[ch]) begin
          dac_q[ch] <= in_q[ch];
        end
        if (commit && word_d[`DDL_BIT_CHAN] == ch[0]) begin
          in_q[ch] <= mask_code(word_d, res_q);
          pend_q[ch] <= 1'b1;
        end else if (!load_s) begin
          pend_q[ch] <= 1'b0;
        end
      end
    end
  end

  // Mode and range sit outside the clear, so power-down never touches codes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_q <= {2{`DDL_RANGE_RST}};
      mode_q <= {2{`DDL_MODE_RST}};
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (commit && word_d[`DDL_BIT_CHAN] == ch[0]) begin
          range_q[ch] <= word_d[`DDL_BIT_RANGE];
          mode_q[ch] <= word_d[`DDL_BIT_SEL_HI:`DDL_BIT_SEL_LO];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_mode_q <= {2{`DDL_MODE_RST}};
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        out_mode_q[ch] <= !sleep_s ? MODE_HIGH_Z : mode_q[ch];
      end
    end
  end

  // ****************************************************************
  // APB slave, one wait state on every access
  // ****************************************************************
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] rd_d;
  logic hit_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      `DDL_OFS_CTRL: rd_d[1:0] = res_q;
      `DDL_OFS_STATUS: rd_d[10:0] = {pend_q, buf_en_q, state_q, 1'b0, cnt_q};
      `DDL_OFS_IN_A: rd_d[DW-1:0] = in_q[0];
      `DDL_OFS_IN_B: rd_d[DW-1:0] = in_q[1];
      `DDL_OFS_DAC_A: rd_d[DW-1:0] = dac_q[0];
      `DDL_OFS_DAC_B: rd_d[DW-1:0] = dac_q[1];
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr_q <= !hit_d || (pwrite && paddr != `DDL_OFS_CTRL);
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= `DDL_CTRL_RST;
    end else if (psel && penable && pready_q && pwrite && paddr == `DDL_OFS_CTRL) begin
      res_q <= pwdata[1:0];
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign code_a = dac_q[0];
  assign code_b = dac_q[1];
  assign range_a = range_q[0];
  assign range_b = range_q[1];
  assign mode_a = out_mode_q[0];
  assign mode_b = out_mode_q[1];
  assign link_awake = buf_en_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_abort_keeps: assert property (@(posedge pclk) disable iff (!clr_n)
    (state_q == FR_SHIFT && sync_s) |=> $stable(in_q))
    else $error("Aborted frame changed an input register.");

  chk_commit_chan: assert property (@(posedge pclk) disable iff (!clr_n)
    (commit && !word_d[`DDL_BIT_CHAN]) |=> in_q[0] == mask_code($past(word_d), $past(res_q))
    && $stable(in_q[1]))
    else $error("Channel A word not loaded as sent.");

  chk_range_mode: assert property (@(posedge pclk) disable iff (!presetn)
    commit |=> range_q[$past(word_d[`DDL_BIT_CHAN])] == $past(word_d[`DDL_BIT_RANGE])
    && mode_q[$past(word_d[`DDL_BIT_CHAN])] == $past(word_d[13:12]))
    else $error("Range or mode bit not taken from the word.");

  chk_ignore_after: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == FR_DONE) |=> $stable(shift_q) && $stable(cnt_q) || $past(sync_s))
    else $error("Shift register moved after the sixteenth edge.");

  chk_buf_off: assert property (@(posedge pclk) disable iff (!presetn)
    commit |=> !buf_en_q ##1 (!buf_en_q || $past(sync_s, 2)))
    else $error("Input buffers stayed awake after a full word.");

  chk_dac_hold: assert property (@(posedge pclk) disable iff (!clr_n)
    load_s |=> $stable(dac_q))
    else $error("DAC register moved while the load strobe was high.");

  chk_pend_only: assert property (@(posedge pclk) disable iff (!clr_n)
    (!load_s && pend_q[1]) |=> dac_q[1] == $past(in_q[1]))
    else $error("Pending channel B did not update while loading.");

  chk_sleep_force: assert property (@(posedge pclk) disable iff (!presetn)
    !sleep_s |=> out_mode_q[0] == MODE_HIGH_Z && out_mode_q[1] == MODE_HIGH_Z)
    else $error("Sleep pin did not force both outputs high impedance.");

  chk_cnt_reset: assert property (@(posedge pclk) disable iff (!presetn)
    sync_s |=> cnt_q == 5'h0)
    else $error("Edge counter not cleared while strobe high.");

  chk_clear_zero: assert property (@(posedge pclk)
    !clr_n |-> in_q == '0 && dac_q == '0 && pend_q == 2'h0)
    else $error("Clear left a nonzero code.");

  chk_commit_b: assert property (@(posedge pclk) disable iff (!clr_n)
    (commit && word_d[`DDL_BIT_CHAN]) |=> in_q[1] == mask_code($past(word_d), $past(res_q))
    && $stable(in_q[0]))
    else $error("Channel B word not loaded as sent.");

  chk_mode_other: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && word_d[`DDL_BIT_CHAN]) |=> $stable(mode_q[0]) && $stable(range_q[0]))
    else $error("A channel B word changed the mode of channel A.");

  chk_wake_fall: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_q[1] && !sync_s) |=> buf_en_q)
    else $error("Input buffers did not wake after the strobe fell.");

  chk_shift_hold: assert property (@(posedge pclk) disable iff (!presetn)
    sync_s |=> $stable(shift_q))
    else $error("Shift register moved while the frame strobe was high.");

  chk_sleep_keeps: assert property (@(posedge pclk) disable iff (!clr_n)
    (!sleep_s && !commit) |=> $stable(in_q))
    else $error("Power-down disturbed an input register.");

endmodule // ddl_top

// ### ddl_host.sv
`timescale 1ns/1ps
module ddl_host (
  output logic sync_n,
  output logic sclk,
  output logic din
);
  // ****
  // Serial master
  // ****
  // The link clock idles high and runs on every send, even when en is clear and no frame is open.
  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // Gives n falling edges MSB first; gap splits the word into two bytes.
  task automatic send(input logic [15:0] w, input int n, input bit en, input bit gap);
    #3;
    sync_n = !en;
    #40;
    for (int i = 0; i < n; i++) begin
      din = w[15 - (i % 16)];
      #40 sclk = 1'b0;
      #40 sclk = 1'b1;
      if (gap && i == 7) #200;
    end
    #40 sync_n = 1'b1;
    // A released data line must not keep showing the last bit.
    din = ~din;
    #80;
  endtask
endmodule // ddl_host

// ### test_dual_dac_serial_load_control.sv
`timescale 1ns/1ps
`include "ddl_cfg.svh"
module test_dual_dac_serial_load_control;
  import ddl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic load_strobe_n = 1'b1;
  logic zero_all_n = 1'b1;
  logic force_sleep_n = 1'b1;
  logic pready, pslverr, sync_n, sclk, din, range_a, range_b, link_awake, erv;
  logic [31:0] prdata, rdv;
  logic [11:0] code_a, code_b;
  logic [1:0] mode_a, mode_b;
  int checks = 0;
  int n_mismatch = 0;
  int cyc = 0;
  ddl_top #(.DW(12)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sync_n(sync_n), .sclk(sclk), .din(din),
    .load_strobe_n(load_strobe_n), .zero_all_n(zero_all_n),
    .force_sleep_n(force_sleep_n), .code_a(code_a), .code_b(code_b),
    .range_a(range_a), .range_b(range_b), .mode_a(mode_a), .mode_b(mode_b),
    .link_awake(link_awake));
  ddl_host host (.sync_n(sync_n), .sclk(sclk), .din(din));
  always #4 pclk = ~pclk;
  // ****
  // Shared tasks
  // ****
  task automatic final_report;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    check(rdv, exp);
    check(erv, e);
  endtask
  task automatic stat(input logic [1:0] exp);
    apb(1'b0, `DDL_OFS_STATUS, 32'h0);
    check(rdv[10:9], exp);
  endtask
  task automatic word(input logic [15:0] w, input int n, input bit en, input bit gap);
    host.send(w, n, en, gap);
    repeat (8) @(posedge pclk);
  endtask
  task automatic pulse;
    load_strobe_n <= 1'b0;
    repeat (6) @(posedge pclk);
    load_strobe_n <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_power;
    check({code_a, code_b, range_a, range_b, mode_a, mode_b, link_awake}, 0);
    rchk(`DDL_OFS_CTRL, 32'h0, 1'b0);
    rchk(8'h18, 32'h0, 1'b1);
    apb(1'b1, `DDL_OFS_STATUS, 32'h1);
    check(erv, 1'b1);
  endtask
  task automatic t_stage;
    word(16'h4ABC, 16, 1'b1, 1'b0);
    check(code_a, 12'h000);
    check(range_a, 1'b1);
    rchk(`DDL_OFS_IN_A, 32'hABC, 1'b0);
    word(16'hB123, 16, 1'b1, 1'b0);
    check(mode_b, 2'b11);
    check(mode_a, 2'b00);
    rchk(`DDL_OFS_IN_B, 32'h123, 1'b0);
    stat(2'b11);
    pulse();
    check(code_a, 12'hABC);
    check(code_b, 12'h123);
    stat(2'b00);
    word(16'h0555, 16, 1'b1, 1'b0);
    stat(2'b01);
    pulse();
    check(code_a, 12'h555);
    check(code_b, 12'h123);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      word({2'b00, m[1:0], 12'h000}, 16, 1'b1, 1'b0);
      check(mode_a, m[1:0]);
    end
  endtask
  task automatic t_res;
    logic [11:0] e;
    for (int r = 0; r < 3; r++) begin
      e = 12'hFFF << (2 * r);
      apb(1'b1, `DDL_OFS_CTRL, r);
      word(16'h0FFF, 16, 1'b1, 1'b0);
      pulse();
      check(code_a, e);
    end
    apb(1'b1, `DDL_OFS_CTRL, 32'h0);
  endtask
  task automatic t_link;
    word(16'h0111, 10, 1'b1, 1'b0);
    stat(2'b00);
    rchk(`DDL_OFS_IN_A, 32'hFF0, 1'b0);
    word(16'h0222, 16, 1'b0, 1'b0);
    stat(2'b00);
    fork
      word(16'h0333, 20, 1'b1, 1'b0);
      begin
        #602 check(link_awake, 1'b1);
        #850 check(link_awake, 1'b0);
      end
    join
    rchk(`DDL_OFS_IN_A, 32'h333, 1'b0);
    word(16'hC456, 16, 1'b1, 1'b1);
    rchk(`DDL_OFS_IN_B, 32'h456, 1'b0);
    check(range_b, 1'b1);
  endtask
  task automatic t_pins;
    force_sleep_n <= 1'b0;
    repeat (5) @(posedge pclk);
    check({mode_a, mode_b}, 4'hF);
    force_sleep_n <= 1'b1;
    repeat (5) @(posedge pclk);
    check({mode_a, mode_b}, 4'h0);
    zero_all_n <= 1'b0;
    repeat (2) @(posedge pclk);
    check({code_a, code_b}, 24'h0);
    rchk(`DDL_OFS_IN_A, 32'h0, 1'b0);
    rchk(`DDL_OFS_IN_B, 32'h0, 1'b0);
    zero_all_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_power();
    t_stage();
    t_modes();
    t_res();
    t_link();
    t_pins();
    final_report();
  end
endmodule // test_dual_dac_serial_load_control
